/* File: src/rcims_irq_top.sv */
/*
 * Interrupt mask and status block of the radio link-layer core.
 * Ten sources latch into raw pending flags; the mask register gates
 * them onto masked status, per-source level outputs and one request line.
 * Assumes event inputs are synchronous to i_clk and come from core logic,
 * and a register master that never needs wait states.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rcims_params.svh"

module rcims_irq_top (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_radio_event_active,
	input  wire logic        i_base_tick_evt,
	input  wire logic        i_receive_evt,
	input  wire logic        i_sleep_end_evt,
	input  wire logic        i_end_event_evt,
	input  wire logic        i_cipher_engine_evt,
	input  wire logic        i_error_evt,
	input  wire logic        i_gross_target_timer_evt,
	input  wire logic        i_fine_target_timer_evt,
	input  wire logic        i_event_prefetch_abort_evt,
	output logic             o_base_tick_irq,
	output logic             o_receive_irq,
	output logic             o_sleep_end_irq,
	output logic             o_end_event_irq,
	output logic             o_cipher_engine_irq,
	output logic             o_error_irq,
	output logic             o_gross_target_timer_irq,
	output logic             o_fine_target_timer_irq,
	output logic             o_event_prefetch_abort_irq,
	output logic             o_soft_irq,
	output logic             o_irq
);

	localparam int unsigned NSRC = `RCIMS_NUM_SOURCES;
	localparam int unsigned PADW = 32 - NSRC;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	rcims_pkg::rcims_sel_e  sel;
	rcims_pkg::rcims_word_t mask_reg;
	rcims_pkg::rcims_word_t mask_next;
	rcims_pkg::rcims_word_t rdata_reg;
	rcims_pkg::rcims_word_t rdata_next;

	logic            wr_ctrl;
	logic            wr_mask;
	logic            wr_ack;
	logic            tick_gate;
	logic            tick_allowed;
	logic            soft_irq_request;
	logic [NSRC-1:0] set_vec;
	logic [NSRC-1:0] ack_vec;
	logic [NSRC-1:0] enable_vec;
	logic [NSRC-1:0] raw_vec;
	logic [NSRC-1:0] masked_vec;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// Anything that misses the map selects nothing: writes are dropped
	// and reads return zero
	always_comb begin
		if (i_addr == `RCIMS_OFS_CTRL) begin
			sel = rcims_pkg::RCIMS_SEL_CTRL;
		end else if (i_addr == `RCIMS_OFS_MASK) begin
			sel = rcims_pkg::RCIMS_SEL_MASK;
		end else if (i_addr == `RCIMS_OFS_MSTAT) begin
			sel = rcims_pkg::RCIMS_SEL_MSTAT;
		end else if (i_addr == `RCIMS_OFS_RAW) begin
			sel = rcims_pkg::RCIMS_SEL_RAW;
		end else if (i_addr == `RCIMS_OFS_ACK) begin
			sel = rcims_pkg::RCIMS_SEL_ACK;
		end else begin
			sel = rcims_pkg::RCIMS_SEL_NONE;
		end
	end

	assign wr_ctrl = i_wr & (sel == rcims_pkg::RCIMS_SEL_CTRL);
	assign wr_mask = i_wr & (sel == rcims_pkg::RCIMS_SEL_MASK);
	assign wr_ack  = i_wr & (sel == rcims_pkg::RCIMS_SEL_ACK);

	////////////////////////////////////////////////////////////////////////
	// Mask register

	// Only the gate and the ten source masks store; 14:10 stay zero
	always_comb begin
		mask_next = mask_reg;
		if (wr_mask) begin
			mask_next = i_wdata & `RCIMS_MASK_WR_BITS;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			mask_reg <= `RCIMS_MASK_RESET;
		end else begin
			mask_reg <= mask_next;
		end
	end

	assign tick_gate = mask_reg[`RCIMS_BIT_TICK_GATE];

	////////////////////////////////////////////////////////////////////////
	// Event steering

	// With the gate low a tick that falls inside a radio event is never
	// latched, so software does not see a stale tick after the event
	assign tick_allowed = ~i_radio_event_active | tick_gate;

	// The request bit has no storage: it acts on the write and reads 0
	assign soft_irq_request = wr_ctrl & i_wdata[`RCIMS_BIT_SOFT_REQ];

	always_comb begin
		set_vec = '0;
		set_vec[`RCIMS_BIT_TICK]     = i_base_tick_evt & tick_allowed;
		set_vec[`RCIMS_BIT_RX]       = i_receive_evt;
		set_vec[`RCIMS_BIT_SLEEP]    = i_sleep_end_evt;
		set_vec[`RCIMS_BIT_EVENT]    = i_end_event_evt;
		set_vec[`RCIMS_BIT_CIPHER]   = i_cipher_engine_evt;
		set_vec[`RCIMS_BIT_ERROR]    = i_error_evt;
		set_vec[`RCIMS_BIT_GROSS]    = i_gross_target_timer_evt;
		set_vec[`RCIMS_BIT_FINE]     = i_fine_target_timer_evt;
		set_vec[`RCIMS_BIT_PREFETCH] = i_event_prefetch_abort_evt;
		set_vec[`RCIMS_BIT_SOFT]     = soft_irq_request;
	end

	// Acknowledge is write-one-to-clear and holds no state of its own
	assign ack_vec = wr_ack ? i_wdata[NSRC-1:0] : '0;

	assign enable_vec = mask_reg[NSRC-1:0];

	////////////////////////////////////////////////////////////////////////
	// Pending flags, one per source

	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : gen_src
			rcims_pending_bit u_bit (
				.i_clk     (i_clk),
				.i_sys_rst (i_sys_rst),
				.i_set     (set_vec[g]),
				.i_clr     (ack_vec[g]),
				.i_enable  (enable_vec[g]),
				.o_raw     (raw_vec[g]),
				.o_masked  (masked_vec[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Interrupt outputs

	// Each level follows its masked flag until acknowledged or its mask bit is cleared
	assign o_base_tick_irq            = masked_vec[`RCIMS_BIT_TICK];
	assign o_receive_irq              = masked_vec[`RCIMS_BIT_RX];
	assign o_sleep_end_irq            = masked_vec[`RCIMS_BIT_SLEEP];
	assign o_end_event_irq            = masked_vec[`RCIMS_BIT_EVENT];
	assign o_cipher_engine_irq        = masked_vec[`RCIMS_BIT_CIPHER];
	assign o_error_irq                = masked_vec[`RCIMS_BIT_ERROR];
	assign o_gross_target_timer_irq   = masked_vec[`RCIMS_BIT_GROSS];
	assign o_fine_target_timer_irq    = masked_vec[`RCIMS_BIT_FINE];
	assign o_event_prefetch_abort_irq = masked_vec[`RCIMS_BIT_PREFETCH];
	assign o_soft_irq                 = masked_vec[`RCIMS_BIT_SOFT];

	assign o_irq = |masked_vec;

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Control and acknowledge bits are write-only actions and read zero
	always_comb begin
		rdata_next = `RCIMS_WORD_ZERO;
		unique case (sel)
			rcims_pkg::RCIMS_SEL_NONE: begin
				rdata_next = `RCIMS_WORD_ZERO;
			end
			rcims_pkg::RCIMS_SEL_CTRL: begin
				rdata_next = `RCIMS_WORD_ZERO;
			end
			rcims_pkg::RCIMS_SEL_MASK: begin
				rdata_next = mask_reg;
			end
			rcims_pkg::RCIMS_SEL_MSTAT: begin
				rdata_next = {{PADW{1'b0}}, masked_vec};
			end
			rcims_pkg::RCIMS_SEL_RAW: begin
				rdata_next = {{PADW{1'b0}}, raw_vec};
			end
			rcims_pkg::RCIMS_SEL_ACK: begin
				rdata_next = `RCIMS_WORD_ZERO;
			end
			default: begin
				rdata_next = `RCIMS_WORD_ZERO;
			end
		endcase
	end

	// Data stand only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_reg <= `RCIMS_WORD_ZERO;
		end else if (i_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= `RCIMS_WORD_ZERO;
		end
	end

	assign o_rdata = rdata_reg;

endmodule

`default_nettype wire

/* File: src/rcims_params.svh */
/*
 * Constants of the radio core interrupt mask and status block: register
 * byte addresses, field positions, reset values and writable-bit masks.
 * Assumes it is included by its bare name from files under src/.
 */
`ifndef RCIMS_PARAMS_SVH
`define RCIMS_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define RCIMS_OFS_CTRL        32'h4000_0000
`define RCIMS_OFS_MASK        32'h4000_000c
`define RCIMS_OFS_MSTAT       32'h4000_0010
`define RCIMS_OFS_RAW         32'h4000_0014
`define RCIMS_OFS_ACK         32'h4000_0018

////////////////////////////////////////////////////////////////////////////////
// Source bit positions, shared by mask, status, raw and acknowledge; then the mask tick gate and the control request bit
`define RCIMS_NUM_SOURCES     10
`define RCIMS_BIT_TICK        0
`define RCIMS_BIT_RX          1
`define RCIMS_BIT_SLEEP       2
`define RCIMS_BIT_EVENT       3
`define RCIMS_BIT_CIPHER      4
`define RCIMS_BIT_ERROR       5
`define RCIMS_BIT_GROSS       6
`define RCIMS_BIT_FINE        7
`define RCIMS_BIT_PREFETCH    8
`define RCIMS_BIT_SOFT        9
`define RCIMS_BIT_TICK_GATE   15
`define RCIMS_BIT_SOFT_REQ    28

////////////////////////////////////////////////////////////////////////////////
// Reset value and writable bits of the mask register
`define RCIMS_MASK_RESET      32'h0000_811f
`define RCIMS_MASK_WR_BITS    32'h0000_83ff
`define RCIMS_WORD_ZERO       32'h0000_0000

`endif

/* File: src/rcims_pkg.sv */
/*
 * Types of the radio core interrupt mask and status block.
 * Assumes nothing beyond a SystemVerilog compiler; no file imports it.
 */
package rcims_pkg;

	typedef logic [31:0] rcims_word_t;

	// One-hot register select produced by the address decoder
	typedef enum logic [5:0] {
		RCIMS_SEL_NONE  = 6'h01,
		RCIMS_SEL_CTRL  = 6'h02,
		RCIMS_SEL_MASK  = 6'h04,
		RCIMS_SEL_MSTAT = 6'h08,
		RCIMS_SEL_RAW   = 6'h10,
		RCIMS_SEL_ACK   = 6'h20
	} rcims_sel_e;

endpackage

/* File: src/rcims_pending_bit.sv */
/*
 * One interrupt source: sticky raw pending flag with its mask applied.
 * Assumes set and clear are single-clock signals from the same domain.
 */
`timescale 1ns/1ns
`default_nettype none

module rcims_pending_bit (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_set,
	input  wire logic i_clr,
	input  wire logic i_enable,
	output logic      o_raw,
	output logic      o_masked
);

	logic pend_reg;
	logic pend_next;

	// Set beats clear so an event landing on the acknowledge is kept
	always_comb begin
		pend_next = i_set | (pend_reg & ~i_clr);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pend_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
		end
	end

	assign o_raw    = pend_reg;
	assign o_masked = pend_reg & i_enable;

endmodule

`default_nettype wire

/* File: sim/rcims_irq_chk.sv */
/* Assertions on the ports of the interrupt mask and status block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
`include "rcims_params.svh"

module rcims_irq_chk (
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        i_receive_evt,
	input wire logic        o_receive_irq,
	input wire logic        o_error_irq,
	input wire logic        o_irq
);

////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_rx_evt;
		i_receive_evt;
	endsequence
	sequence s_raw_rd;
		i_rd && i_addr == `RCIMS_OFS_RAW;
	endsequence
	// No write between event and read, so no acknowledge can intervene
	sequence s_no_wr;
		!i_wr;
	endsequence

	property p_raw_set;
		s_rx_evt ##1 s_no_wr ##1 s_raw_rd |=> o_rdata[1];
	endproperty
	property p_rd_idle;
		!i_rd |=> o_rdata == 32'h0;
	endproperty
	property p_mask_rd;
		i_rd && i_addr == `RCIMS_OFS_MASK
			|=> o_rdata[31:16] == 16'h0 && o_rdata[14:10] == 5'h0;
	endproperty
	// Status is nonzero exactly when the request line was up
	property p_stat_rd;
		i_rd && i_addr == `RCIMS_OFS_MSTAT
			|=> o_rdata[31:10] == 22'h0 && (|o_rdata) == $past(o_irq);
	endproperty
	property p_ack_clr;
		i_wr && i_addr == `RCIMS_OFS_ACK && i_wdata[1] && !i_receive_evt
			|=> !o_receive_irq;
	endproperty
	property p_rx_or;
		o_receive_irq |-> o_irq;
	endproperty
	property p_err_hold;
		o_error_irq && !i_wr |=> o_error_irq;
	endproperty
	property p_rx_cause;
		$rose(o_receive_irq) |-> $past(i_receive_evt || i_wr);
	endproperty

	a_raw_set: assert property (p_raw_set)
		else $error("raw receive bit missing");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero when idle");
	a_mask_rd: assert property (p_mask_rd)
		else $error("reserved mask bits not zero");
	a_stat_rd: assert property (p_stat_rd)
		else $error("masked status disagrees with request line");
	a_ack_clr: assert property (p_ack_clr)
		else $error("acknowledge did not clear receive");
	a_rx_or: assert property (p_rx_or)
		else $error("request line low with receive pending");
	a_err_hold: assert property (p_err_hold)
		else $error("error level dropped without a write");
	a_rx_cause: assert property (p_rx_cause)
		else $error("receive raised without cause");

endmodule

bind rcims_irq_top rcims_irq_chk rcims_irq_chk_inst (
	.i_clk         (i_clk),
	.i_sys_rst     (i_sys_rst),
	.i_addr        (i_addr),
	.i_wdata       (i_wdata),
	.i_wr          (i_wr),
	.i_rd          (i_rd),
	.o_rdata       (o_rdata),
	.i_receive_evt (i_receive_evt),
	.o_receive_irq (o_receive_irq),
	.o_error_irq   (o_error_irq),
	.o_irq         (o_irq)
);
`default_nettype wire

/* File: sim/rcims_cpu_model.sv */
/* Processor side of the register bus: single writes and reads.
   Assumes a slave with no wait states and read data one cycle late. */
`timescale 1ns/1ns
`default_nettype none

module rcims_cpu_model (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	output var  logic [31:0] o_addr,
	output var  logic [31:0] o_wdata,
	output var  logic        o_wr,
	output var  logic        o_rd
);

	initial begin
		o_addr = 32'h0;
		o_wdata = 32'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// Acknowledge is a write of ones to the acknowledge word
	// Address and data are scrambled when idle so stale values never help
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask

endmodule
`default_nettype wire

/* File: sim/rcims_tb_top.sv */
/* Self-checking bench of the interrupt mask and status block.
   Assumes the processor model and the bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
`include "rcims_params.svh"

`define CHK(n, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("BAD %s exp %h got %h", n, e, g); \
	end \
end

module rcims_tb_top;
	logic        i_clk;
	logic        i_sys_rst;
	logic        i_radio_event_active;
	logic [8:0]  evt;
	wire  [31:0] i_addr, i_wdata, o_rdata;
	wire         i_wr, i_rd, o_irq;
	wire         i_base_tick_evt, i_receive_evt, i_sleep_end_evt;
	wire         i_end_event_evt, i_cipher_engine_evt, i_error_evt;
	wire         i_gross_target_timer_evt, i_fine_target_timer_evt;
	wire         i_event_prefetch_abort_evt;
	wire         o_base_tick_irq, o_receive_irq, o_sleep_end_irq;
	wire         o_end_event_irq, o_cipher_engine_irq, o_error_irq;
	wire         o_gross_target_timer_irq, o_fine_target_timer_irq;
	wire         o_event_prefetch_abort_irq, o_soft_irq;
	wire  [9:0]  irqs;
	int          miscompares = 0;
	int          n_tests = 0;

	assign {i_event_prefetch_abort_evt, i_fine_target_timer_evt,
		i_gross_target_timer_evt, i_error_evt, i_cipher_engine_evt,
		i_end_event_evt, i_sleep_end_evt, i_receive_evt,
		i_base_tick_evt} = evt;
	assign irqs = {o_soft_irq, o_event_prefetch_abort_irq,
		o_fine_target_timer_irq, o_gross_target_timer_irq, o_error_irq,
		o_cipher_engine_irq, o_end_event_irq, o_sleep_end_irq,
		o_receive_irq, o_base_tick_irq};

	rcims_irq_top rcims_irq_top_inst (
		.i_clk                      (i_clk),
		.i_sys_rst                  (i_sys_rst),
		.i_addr                     (i_addr),
		.i_wdata                    (i_wdata),
		.i_wr                       (i_wr),
		.i_rd                       (i_rd),
		.o_rdata                    (o_rdata),
		.i_radio_event_active       (i_radio_event_active),
		.i_base_tick_evt            (i_base_tick_evt),
		.i_receive_evt              (i_receive_evt),
		.i_sleep_end_evt            (i_sleep_end_evt),
		.i_end_event_evt            (i_end_event_evt),
		.i_cipher_engine_evt        (i_cipher_engine_evt),
		.i_error_evt                (i_error_evt),
		.i_gross_target_timer_evt   (i_gross_target_timer_evt),
		.i_fine_target_timer_evt    (i_fine_target_timer_evt),
		.i_event_prefetch_abort_evt (i_event_prefetch_abort_evt),
		.o_base_tick_irq            (o_base_tick_irq),
		.o_receive_irq              (o_receive_irq),
		.o_sleep_end_irq            (o_sleep_end_irq),
		.o_end_event_irq            (o_end_event_irq),
		.o_cipher_engine_irq        (o_cipher_engine_irq),
		.o_error_irq                (o_error_irq),
		.o_gross_target_timer_irq   (o_gross_target_timer_irq),
		.o_fine_target_timer_irq    (o_fine_target_timer_irq),
		.o_event_prefetch_abort_irq (o_event_prefetch_abort_irq),
		.o_soft_irq                 (o_soft_irq),
		.o_irq                      (o_irq)
	);
	rcims_cpu_model rcims_cpu_model_inst (.i_clk(i_clk), .i_rdata(o_rdata),
		.o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic w(input logic [31:0] a, input logic [31:0] d);
		rcims_cpu_model_inst.wr_reg(a, d);
	endtask

	task automatic r(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		rcims_cpu_model_inst.rd_reg(a, d);
		`CHK("read", e, d)
	endtask

	// Event pulse lasts one cycle; the flag is taken at the next edge
	task automatic pulse(input int i);
		@(posedge i_clk);
		evt[i] <= 1'b1;
		@(posedge i_clk);
		evt <= 9'h0;
	endtask

////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		miscompares++;
		end_of_test;
	end

	initial begin
		i_sys_rst = 1'b1;
		i_radio_event_active = 1'b0;
		evt = 9'h0;
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		r(`RCIMS_OFS_MASK, 32'h0000811f);
		r(`RCIMS_OFS_MSTAT, 32'h0);
		r(`RCIMS_OFS_RAW, 32'h0);
		w(`RCIMS_OFS_MASK, 32'hffffffff);
		r(`RCIMS_OFS_MASK, 32'h000083ff);
		for (int i = 0; i < 9; i++) begin
			pulse(i);
			r(`RCIMS_OFS_RAW, 32'h1 << i);
			r(`RCIMS_OFS_MSTAT, 32'h1 << i);
			`CHK("irq", {1'b1, 10'h1 << i}, {o_irq, irqs})
			w(`RCIMS_OFS_MASK, 32'h00008000);
			r(`RCIMS_OFS_MSTAT, 32'h0);
			`CHK("irq", 11'h0, {o_irq, irqs})
			w(`RCIMS_OFS_MASK, 32'h0000ffff);
			w(`RCIMS_OFS_ACK, 32'h1 << i);
			r(`RCIMS_OFS_RAW, 32'h0);
		end
		w(`RCIMS_OFS_MASK, 32'h000081ff);
		w(`RCIMS_OFS_CTRL, 32'h10000000);
		r(`RCIMS_OFS_RAW, 32'h00000200);
		r(`RCIMS_OFS_MSTAT, 32'h0);
		r(`RCIMS_OFS_CTRL, 32'h0);
		w(`RCIMS_OFS_MASK, 32'h000083ff);
		r(`RCIMS_OFS_MSTAT, 32'h00000200);
		`CHK("soft", 2'h3, {o_soft_irq, o_irq})
		w(`RCIMS_OFS_ACK, 32'h00000200);
		r(`RCIMS_OFS_ACK, 32'h0);
		r(`RCIMS_OFS_RAW, 32'h0);
		w(`RCIMS_OFS_MASK, 32'h00000001);
		@(posedge i_clk);
		i_radio_event_active <= 1'b1;
		pulse(0);
		r(`RCIMS_OFS_RAW, 32'h0);
		w(`RCIMS_OFS_MASK, 32'h00008001);
		pulse(0);
		r(`RCIMS_OFS_RAW, 32'h1);
		// Reset in mid-run with a tick pending and the mask changed
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		r(`RCIMS_OFS_RAW, 32'h0);
		r(`RCIMS_OFS_MSTAT, 32'h0);
		r(`RCIMS_OFS_MASK, 32'h0000811f);
		`CHK("irq", 11'h0, {o_irq, irqs})
		r(32'h40000020, 32'h0);
		end_of_test;
	end

endmodule
`default_nettype wire
